// ### common/tlpi_pkg.sv
// Contract
// - High-priority accepts go to vector 0008h, low-priority accepts to 0018h.
// - An enabled pending high-priority interrupt pre-empts a running low-priority routine.
// - Each source has an event flag, an enable and a priority bit.
// - Two-level mode only while priority_mode_enable is set; cleared at reset.
// - In priority mode control bit 7 enables all high-priority sources.
// - In priority mode control bit 6 enables all low-priority sources.
// - Flag, enable and matching global enable set means vector to chosen address.
// - In compatibility mode priority bits have no effect.
// - In compatibility mode bit 6 gates peripherals and bit 7 gates everything.
// - In compatibility mode every accepted interrupt vectors to 0008h.
// - Accepting clears the global enable that admitted the interrupt.
// - No low-priority interrupt is accepted during a high-priority routine.
// - Vectoring pushes the return address and loads the vector into the PC.
// - Return-from-interrupt leaves the routine and sets the enable cleared on entry; here a return in the same cycle as an accept is ignored.
// - Pin and port-change latency is three to four cycles, instruction length aside.
// - Flags set on their event whatever the enable bits.
// - Each external pin has an edge select: 1 rising, 0 falling.
package tlpi_pkg;

  // ****************************************
  // Sizes and map
  // ****************************************
  localparam int NSRC = 8;
  localparam int NPIN = 3;
  localparam int PC_W = 21;
  // Sources 0..2 external pins, 3 port change, 4 timer; 5..7 peripherals
  localparam logic [NSRC-1:0] PERIPH_MASK = 8'hE0;
  localparam logic [NSRC-1:0] PIN_MASK = 8'h07;
  localparam logic [NSRC-1:0] PORTCHG_MASK = 8'h08;

  // ****************************************
  // Register offsets and fields
  // ****************************************
  localparam logic [3:0] ADDR_RESET_CTRL = 4'h0;
  localparam logic [3:0] ADDR_INT_CTRL = 4'h1;
  localparam logic [3:0] ADDR_FLAG = 4'h2;
  localparam logic [3:0] ADDR_ENABLE = 4'h3;
  localparam logic [3:0] ADDR_PRIORITY = 4'h4;
  localparam logic [3:0] ADDR_EDGE = 4'h5;
  localparam logic [3:0] ADDR_STATUS = 4'h6;
  localparam int BIT_PRIO_MODE = 7;
  localparam int BIT_GIE_HIGH = 7;
  localparam int BIT_GIE_LOW = 6;
  localparam logic [7:0] RESET_CTRL_RST = 8'h00;
  localparam logic [7:0] INT_CTRL_RST = 8'h00;
  localparam logic [7:0] FLAG_RST = 8'h00;
  localparam logic [7:0] ENABLE_RST = 8'h00;
  localparam logic [7:0] PRIORITY_RST = 8'hFF;
  localparam logic [NPIN-1:0] EDGE_RST = 3'h7;

  // ****************************************
  // Vectors and timing
  // ****************************************
  localparam logic [PC_W-1:0] VEC_HIGH = 21'h000008;
  localparam logic [PC_W-1:0] VEC_LOW = 21'h000018;
  localparam logic [1:0] LAT_CYCLES = 2'h3;

  typedef struct packed {
    logic valid;
    logic [PC_W-1:0] vector;
    logic high;
  } tlpi_vec_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_TAKE = 3'b100
  } tlpi_state_t;

  function automatic logic [7:0] tlpi_sel(input logic [3:0] a, input logic [3:0] k,
                                          input logic [7:0] v);
    return (a == k) ? v : 8'h00;
  endfunction

endpackage

// ### verilog/tlpi_ctrl.sv
`timescale 1ns/1ps
module tlpi_ctrl
  import tlpi_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [NPIN-1:0] ext_pin,
  input wire logic [NSRC-1:0] src_event,
  input wire logic instr_boundary,
  input wire logic [PC_W-1:0] return_pc,
  input wire logic return_from_interrupt_instr,
  output logic vector_take,
  output logic [PC_W-1:0] vector_pc,
  output logic stack_push,
  output logic [PC_W-1:0] stack_push_data,
  output logic in_high_service,
  output logic in_low_service
);

  // ****************************************
  // Registers
  // ****************************************
  logic priority_mode_enable;
  logic high_level_global_enable;
  logic low_level_global_enable;
  logic [2:0] ctrl_misc;
  logic [NSRC-1:0] flag;
  logic [NSRC-1:0] enable;
  logic [NSRC-1:0] prio;
  logic [NPIN-1:0] ext_pin0_edge_select;
  logic [NPIN-1:0] pin_prev;
  logic [1:0] lat_cnt;
  tlpi_state_t state;
  tlpi_vec_t pend;

  // ****************************************
  // Decode
  // ****************************************
  wire logic wr_rst = reg_wr && reg_addr == ADDR_RESET_CTRL;
  wire logic wr_ic = reg_wr && reg_addr == ADDR_INT_CTRL;
  wire logic wr_flag = reg_wr && reg_addr == ADDR_FLAG;
  // Pin edge per select bit
  wire logic [NPIN-1:0] pin_edge = ext_pin0_edge_select & ext_pin & ~pin_prev
                                 | ~ext_pin0_edge_select & ~ext_pin & pin_prev;
  wire logic [NSRC-1:0] evt = src_event | {{(NSRC-NPIN){1'b0}}, pin_edge};
  wire logic [NSRC-1:0] active = flag & enable;
  // Compatibility mode ignores prio entirely
  wire logic [NSRC-1:0] eff_prio = priority_mode_enable ? prio : {NSRC{1'b1}};
  wire logic [NSRC-1:0] compat_ok = active & (~PERIPH_MASK | {NSRC{low_level_global_enable}});
  wire logic req_high = priority_mode_enable
                      ? high_level_global_enable && |(active & eff_prio)
                      : high_level_global_enable && |compat_ok;
  // Low level blocked while high service runs
  wire logic req_low = priority_mode_enable && low_level_global_enable && !in_high_service
                     && |(active & ~eff_prio);
  wire logic fast_src = |((active & eff_prio & ~(PIN_MASK | PORTCHG_MASK)));
  wire tlpi_vec_t next_pend = '{valid: req_high || req_low,
                                vector: req_high ? VEC_HIGH : VEC_LOW,
                                high: req_high};
  wire logic [7:0] rd_mux = tlpi_sel(reg_addr, ADDR_RESET_CTRL, {priority_mode_enable, 7'h00})
    | tlpi_sel(reg_addr, ADDR_INT_CTRL,
               {high_level_global_enable, low_level_global_enable, 3'h0, ctrl_misc})
    | tlpi_sel(reg_addr, ADDR_FLAG, flag)
    | tlpi_sel(reg_addr, ADDR_ENABLE, enable)
    | tlpi_sel(reg_addr, ADDR_PRIORITY, prio)
    | tlpi_sel(reg_addr, ADDR_EDGE, {5'h00, ext_pin0_edge_select})
    | tlpi_sel(reg_addr, ADDR_STATUS, {6'h00, in_high_service, in_low_service});
  // Same qualifiers as the sequencer, so a dropped request never clears an enable
  wire logic take = state == ST_TAKE && next_pend.valid && instr_boundary;
  wire logic ret = return_from_interrupt_instr && (in_high_service || in_low_service);

  // ****************************************
  // Bus and configuration
  // ****************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      priority_mode_enable <= RESET_CTRL_RST[BIT_PRIO_MODE];
      enable <= ENABLE_RST;
      prio <= PRIORITY_RST;
      ext_pin0_edge_select <= EDGE_RST;
      ctrl_misc <= INT_CTRL_RST[2:0];
      reg_rdata <= 8'h00;
      pin_prev <= '0;
    end else if (clk_en) begin
      pin_prev <= ext_pin;
      reg_rdata <= reg_rd ? rd_mux : 8'h00;
      if (wr_rst) begin
        priority_mode_enable <= reg_wdata[BIT_PRIO_MODE];
      end
      if (wr_ic) begin
        ctrl_misc <= reg_wdata[2:0];
      end
      if (reg_wr && reg_addr == ADDR_ENABLE) begin
        enable <= reg_wdata;
      end
      if (reg_wr && reg_addr == ADDR_PRIORITY) begin
        prio <= reg_wdata;
      end
      if (reg_wr && reg_addr == ADDR_EDGE) begin
        ext_pin0_edge_select <= reg_wdata[NPIN-1:0];
      end
    end
  end

  // ****************************************
  // Flags: event wins over software clear
  // ****************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      flag <= FLAG_RST;
    end else if (clk_en) begin
      flag <= (wr_flag ? reg_wdata : flag) | evt;
    end
  end

  // ****************************************
  // Global enables and service level
  // ****************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      high_level_global_enable <= INT_CTRL_RST[BIT_GIE_HIGH];
      low_level_global_enable <= INT_CTRL_RST[BIT_GIE_LOW];
      in_high_service <= 1'b0;
      in_low_service <= 1'b0;
    end else if (clk_en) begin
      if (wr_ic) begin
        high_level_global_enable <= reg_wdata[BIT_GIE_HIGH];
        low_level_global_enable <= reg_wdata[BIT_GIE_LOW];
      end
      if (take) begin
        // Compat mode takes every request at the high level (pend.high) and bit 7 gates all of them, so clearing it is right
        if (pend.high) begin
          high_level_global_enable <= 1'b0;
          in_high_service <= 1'b1;
        end else begin
          low_level_global_enable <= 1'b0;
          in_low_service <= 1'b1;
        end
      end else if (ret) begin
        // Innermost level returns first; low service resumes underneath
        if (in_high_service) begin
          high_level_global_enable <= 1'b1;
          in_high_service <= 1'b0;
        end else begin
          low_level_global_enable <= 1'b1;
          in_low_service <= 1'b0;
        end
      end
    end
  end

  // ****************************************
  // Acceptance sequencer
  // ****************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      state <= ST_IDLE;
      pend <= '0;
      lat_cnt <= 2'h0;
      vector_take <= 1'b0;
      vector_pc <= '0;
      stack_push <= 1'b0;
      stack_push_data <= '0;
    end else if (clk_en) begin
      vector_take <= 1'b0;
      stack_push <= 1'b0;
      case (state)
        ST_IDLE: begin
          // High request pre-empts a running low routine
          if (next_pend.valid) begin
            pend <= next_pend;
            lat_cnt <= fast_src ? 2'h1 : LAT_CYCLES - 2'h1;
            state <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          // Count is 1 for fast sources and 2 otherwise; ST_TAKE still waits for instr_boundary, so instruction length adds latency
          if (lat_cnt <= 2'h1) begin
            state <= ST_TAKE;
          end else begin
            lat_cnt <= lat_cnt - 2'h1;
          end
        end
        ST_TAKE: begin
          if (!next_pend.valid) begin
            state <= ST_IDLE;
          end else if (instr_boundary) begin
            vector_take <= 1'b1;
            vector_pc <= pend.vector;
            stack_push <= 1'b1;
            stack_push_data <= return_pc;
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

endmodule

// ### sim/tlpi_ctrl_monitor.sv
`timescale 1ns/1ps
module tlpi_ctrl_monitor
  import tlpi_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [PC_W-1:0] return_pc,
  input wire logic return_from_interrupt_instr,
  input wire logic vector_take,
  input wire logic [PC_W-1:0] vector_pc,
  input wire logic stack_push,
  input wire logic [PC_W-1:0] stack_push_data,
  input wire logic in_high_service,
  input wire logic in_low_service
);
  // ****************************************
  // Vectoring and service levels
  // ****************************************
  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  high_vector_a: assert property (
    $rose(in_high_service) |-> vector_take && vector_pc == VEC_HIGH)
    else $error("high service entered without high vector");
  low_vector_a: assert property (
    $rose(in_low_service) |-> vector_take && vector_pc == VEC_LOW)
    else $error("low service entered without low vector");
  push_pair_a: assert property (
    vector_take |-> stack_push && stack_push_data == $past(return_pc))
    else $error("vector taken without matching stack push");
  low_blocked_a: assert property (
    in_high_service |=> !$rose(in_low_service))
    else $error("low interrupt accepted during high service");
  high_return_a: assert property (
    return_from_interrupt_instr && in_high_service |=> !in_high_service)
    else $error("return did not end high service");
  low_resume_a: assert property (
    return_from_interrupt_instr && in_high_service && in_low_service |=> in_low_service)
    else $error("low service lost on return from high");
  take_pulse_a: assert property (
    vector_take |=> !vector_take)
    else $error("vector take longer than one cycle");
  vector_hold_a: assert property (
    !vector_take |-> $stable(vector_pc))
    else $error("vector address moved without a take");
endmodule

bind tlpi_ctrl tlpi_ctrl_monitor i_tlpi_ctrl_monitor(.clk, .reset, .return_pc,
  .return_from_interrupt_instr, .vector_take, .vector_pc, .stack_push, .stack_push_data,
  .in_high_service, .in_low_service);

// ### sim/tlpi_cpu_model.sv
`timescale 1ns/1ps
module tlpi_cpu_model
  import tlpi_pkg::*;
(
  input wire logic clk,
  input wire logic slow,
  output logic instr_boundary,
  output logic [PC_W-1:0] return_pc
);
  // ****************************************
  // Core sequencer stand-in
  // ****************************************
  localparam logic [PC_W-1:0] RET_PC = 21'h001234;
  logic [1:0] cnt = 2'h0;
  always @(posedge clk) begin
    cnt <= cnt + 2'h1;
  end
  // Slow mode mimics two-cycle instructions so boundaries come every other cycle
  assign instr_boundary = !slow || cnt[0];
  assign return_pc = RET_PC;
endmodule

// ### sim/test_tlpi_ctrl.sv
`timescale 1ns/1ps
module test_tlpi_ctrl
  import tlpi_pkg::*;
;
  // ****************************************
  // Harness
  // ****************************************
  logic clk = 0, reset = 1, reg_wr = 0, reg_rd = 0, ret = 0, slow = 0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata;
  logic [NPIN-1:0] ext_pin = 3'h0;
  logic [NSRC-1:0] src_event = 8'h00;
  logic ib, vector_take, stack_push, hs, ls;
  logic [PC_W-1:0] rpc, vector_pc, spd;
  int fail_count = 0, comparisons = 0, cyc = 0;
  always #4 clk = !clk;
  tlpi_ctrl i_tlpi_ctrl(.clk, .reset, .clk_en(1'b1), .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .ext_pin, .src_event, .instr_boundary(ib), .return_pc(rpc),
    .return_from_interrupt_instr(ret), .vector_take, .vector_pc, .stack_push,
    .stack_push_data(spd), .in_high_service(hs), .in_low_service(ls));
  tlpi_cpu_model i_tlpi_cpu_model(.clk, .slow, .instr_boundary(ib), .return_pc(rpc));

  task chk(input string n, input logic [PC_W-1:0] e, input logic [PC_W-1:0] g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task conclude;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1; reg_addr <= a; reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 0;
  endtask
  task rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_rd <= 1; reg_addr <= a;
    @(posedge clk);
    reg_rd <= 0;
    #1 chk("reg_rdata", e, reg_rdata);
  endtask
  task ev(input int i);
    @(posedge clk);
    src_event <= 8'h01 << i;
    @(posedge clk);
    src_event <= 8'h00;
  endtask
  task take(input logic [PC_W-1:0] v);
    for (int n = 0; n < 12 && vector_take !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    chk("vector_take", 1, vector_take);
    chk("vector_pc", v, vector_pc);
    chk("stack_push", 1, stack_push);
    chk("stack_push_data", 21'h001234, spd);
  endtask
  task quiet;
    repeat (12) begin
      @(posedge clk);
      #1 chk("vector_take", 0, vector_take);
    end
  endtask
  task rt;
    @(posedge clk);
    ret <= 1;
    @(posedge clk);
    ret <= 0;
  endtask

  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    repeat (2) @(posedge clk);
    reset <= 0;
    rd(ADDR_RESET_CTRL, RESET_CTRL_RST);
    rd(ADDR_PRIORITY, PRIORITY_RST);
    rd(ADDR_EDGE, {5'h00, EDGE_RST});
    rd(4'hF, 8'h00);
    ev(4); rd(ADDR_FLAG, 8'h10);
    wr(ADDR_FLAG, 8'h00);
    wr(ADDR_RESET_CTRL, 8'h80); wr(ADDR_PRIORITY, 8'hEF); wr(ADDR_ENABLE, 8'h30);
    wr(ADDR_INT_CTRL, 8'hC0);
    ev(4); take(VEC_LOW);
    rd(ADDR_INT_CTRL, 8'h80);
    ev(5); take(VEC_HIGH);
    rd(ADDR_STATUS, 8'h03); rd(ADDR_INT_CTRL, 8'h00);
    wr(ADDR_FLAG, 8'h00); wr(ADDR_INT_CTRL, 8'h40);
    ev(4); quiet;
    wr(ADDR_FLAG, 8'h00); rt; rd(ADDR_INT_CTRL, 8'hC0);
    rd(ADDR_STATUS, 8'h01); rt; rd(ADDR_STATUS, 8'h00);
    @(posedge clk);
    slow <= 1;
    wr(ADDR_RESET_CTRL, 8'h00); wr(ADDR_INT_CTRL, 8'h80); wr(ADDR_PRIORITY, 8'h00);
    ev(5); quiet;
    ev(4); take(VEC_HIGH);
    rd(ADDR_INT_CTRL, 8'h00);
    wr(ADDR_FLAG, 8'h00); rt; rd(ADDR_INT_CTRL, 8'h80);
    wr(ADDR_EDGE, 8'h06); ext_pin <= 3'h3;
    repeat (4) @(posedge clk);
    rd(ADDR_FLAG, 8'h02);
    @(posedge clk);
    ext_pin <= 3'h2;
    repeat (4) @(posedge clk);
    rd(ADDR_FLAG, 8'h03);
    conclude;
  end
  // Ceiling well above the under two hundred cycles the sequence needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      conclude;
    end
  end
endmodule
